// file: hdl/reference_search.sv
// Purpose: reference search (homing) sequencer for one stepper axis
// Assumes: motor position and switch levels are synchronous to clk_sys
// Notes: registers on classic Wishbone, one ack per request
//
// Function
// - Homing state machine is started and stopped by command opcode 13, polled by reading the command or status register.
// - End-switch auto-stop settings have no effect while homing runs.
// - Fast search speed is used until the switch is first detected.
// - Creep off the switch, re-enter from the side it left, zero at midpoint.
// - Calibration creeping uses the calibration speed register.
// - Mode register picks one of eight search strategies, base values 1 to 8.
// - Mode 1 seeks left switch only; 65 seeks right switch only.
// - Mode 2 finds right switch, then left; left is zero.
// - Mode 2 stores the switch-to-switch distance in microsteps.
// - Mode 66 finds left switch first; right switch is zero.
// - Mode 3 decodes as mode 2: finds right, then left edge; stores that distance.
// - Mode 67 finds left first; right switch edge is zero, as in mode 66.
// - Mode 4 zeros on left switch edge as mode 1; mode 68 on right switch edge as mode 65.
// - Mode 5 seeks home negative, reversing at the left limit.
// - Mode 6 seeks home positive, reversing at the right limit.
// - Adding 128 to modes 5 to 8 inverts home switch polarity.
// - Mode 7 seeks home positive, ignores limits, zeros at the home edge reached.
// - Mode 8 seeks home negative, ignores limits, zeros at the home edge reached.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module reference_search
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [homing_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Switches and motor feedback
  input homing_pkg::switch_type switches,
  input wire logic signed [homing_pkg::POS_W-1:0] actual_position,
  // Motor command
  output homing_pkg::motion_type motion,
  output logic busy
);

  homing_pkg::state_type r;
  homing_pkg::state_type next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic [5:0] base;
  logic swap;
  logic invert;
  logic two_switch;
  logic home_mode;
  logic limit_reverse;
  logic final_neg;
  logic final_hit;
  logic first_hit;
  logic home_active;

  always_comb
  begin
    base = r.mode[5:0];
    swap = r.mode[homing_pkg::MODE_SWAP_BIT];
    invert = r.mode[homing_pkg::MODE_INVERT_BIT];
    home_active = switches.home;
    two_switch = 1'b0;
    home_mode = 1'b0;
    limit_reverse = 1'b0;
    final_neg = 1'b1;
    unique case (base)
      homing_pkg::MODE_LEFT_ONLY, homing_pkg::MODE_LEFT_MID:
      begin
        final_neg = !swap;
      end
      homing_pkg::MODE_RIGHT_LEFT, homing_pkg::MODE_RIGHT_LEFT_MID:
      begin
        two_switch = 1'b1;
        final_neg = !swap;
      end
      homing_pkg::MODE_HOME_NEG_REV:
      begin
        home_mode = 1'b1;
        limit_reverse = 1'b1;
      end
      homing_pkg::MODE_HOME_POS_REV:
      begin
        home_mode = 1'b1;
        limit_reverse = 1'b1;
        final_neg = 1'b0;
      end
      homing_pkg::MODE_HOME_POS:
      begin
        home_mode = 1'b1;
        final_neg = 1'b0;
      end
      homing_pkg::MODE_HOME_NEG:
      begin
        home_mode = 1'b1;
      end
      default:
      begin
        // Unlisted values act as mode 1
        final_neg = !swap;
      end
    endcase
    if (home_mode && invert)
    begin
      home_active = !switches.home;
    end
    // End-switch modes: final switch lies in the direction of travel
    if (home_mode)
    begin
      final_hit = home_active;
    end
    else
    begin
      final_hit = final_neg ? switches.left : switches.right;
    end
    // First switch of two-switch modes is the opposite end
    first_hit = final_neg ? switches.right : switches.left;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  logic signed [homing_pkg::POS_W:0] mid_sum;
  logic signed [homing_pkg::POS_W-1:0] mid_pos;
  logic signed [homing_pkg::POS_W-1:0] span;

  always_comb
  begin
    // Widened sum so that far-apart edges cannot overflow
    mid_sum = {r.edge_pos[homing_pkg::POS_W-1], r.edge_pos}
      + {actual_position[homing_pkg::POS_W-1], actual_position};
    mid_pos = mid_sum[homing_pkg::POS_W:1];
    span = r.first_pos - mid_pos;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic bus_req;
  logic bus_wr;
  logic cmd_ok;
  logic cmd_start;
  logic cmd_stop;
  logic [1:0] cmd_type;
  logic [31:0] status_word;
  logic [31:0] wr_mode, wr_search, wr_cal;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] din,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  always_comb
  begin
    bus_req = wb_cyc_i && wb_stb_i && !r.ack;
    bus_wr = bus_req && wb_we_i;
    cmd_type = wb_dat_i[homing_pkg::CMD_TYPE_LSB +: 2];
    cmd_ok = bus_wr && (wb_adr_i == homing_pkg::OFS_COMMAND) && wb_sel_i[0]
      && wb_sel_i[1]
      && (wb_dat_i[homing_pkg::CMD_OP_LSB +: 8] == homing_pkg::OPCODE_REF_SEARCH);
    cmd_start = cmd_ok && (cmd_type == homing_pkg::CMD_START);
    cmd_stop = cmd_ok && (cmd_type == homing_pkg::CMD_STOP);
    status_word = {28'h0000000, r.phase, r.busy};
    wr_mode = merge({24'h000000, r.mode}, wb_dat_i, wb_sel_i);
    wr_search = merge({8'h00, r.search_speed}, wb_dat_i, wb_sel_i);
    wr_cal = merge({8'h00, r.cal_speed}, wb_dat_i, wb_sel_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_r = r;
    next_r.ack = bus_req;
    next_r.motion.load = 1'b0;

    // Register reads, answered with the ack
    next_r.rdata = 32'h00000000;
    if (bus_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        homing_pkg::OFS_COMMAND, homing_pkg::OFS_STATUS:
        begin
          next_r.rdata = status_word;
        end
        homing_pkg::OFS_MODE:
        begin
          next_r.rdata = {24'h000000, r.mode};
        end
        homing_pkg::OFS_SEARCH_SPEED:
        begin
          next_r.rdata = {8'h00, r.search_speed};
        end
        homing_pkg::OFS_CAL_SPEED:
        begin
          next_r.rdata = {8'h00, r.cal_speed};
        end
        homing_pkg::OFS_DISTANCE:
        begin
          next_r.rdata = r.distance;
        end
        default:
        begin
          next_r.rdata = 32'h00000000;
        end
      endcase
    end

    // Parameter writes; unmapped writes are acked and dropped
    if (bus_wr)
    begin
      unique case (wb_adr_i)
        homing_pkg::OFS_MODE:
        begin
          next_r.mode = wr_mode[7:0];
        end
        homing_pkg::OFS_SEARCH_SPEED:
        begin
          next_r.search_speed = wr_search[homing_pkg::VEL_W-1:0];
        end
        homing_pkg::OFS_CAL_SPEED:
        begin
          next_r.cal_speed = wr_cal[homing_pkg::VEL_W-1:0];
        end
        default:
        begin
          next_r.mode = r.mode;
        end
      endcase
    end

    // Sequencer; limit auto-stop enables are never consulted here
    unique case (r.phase)
      homing_pkg::PH_IDLE:
      begin
        if (cmd_start)
        begin
          next_r.busy = 1'b1;
          if (two_switch)
          begin
            next_r.dir_neg = !final_neg;
            next_r.phase = homing_pkg::PH_FIRST;
          end
          else
          begin
            next_r.dir_neg = final_neg;
            next_r.phase = homing_pkg::PH_SEEK;
          end
        end
      end
      homing_pkg::PH_FIRST:
      begin
        if (first_hit)
        begin
          next_r.first_pos = actual_position;
          next_r.dir_neg = final_neg;
          next_r.phase = homing_pkg::PH_SEEK;
        end
      end
      homing_pkg::PH_SEEK:
      begin
        if (final_hit)
        begin
          // Back off slowly to find the releasing edge
          next_r.dir_neg = !r.dir_neg;
          next_r.phase = homing_pkg::PH_LEAVE;
        end
        else if (limit_reverse && r.dir_neg && switches.left)
        begin
          next_r.dir_neg = 1'b0;
        end
        else if (limit_reverse && !r.dir_neg && switches.right)
        begin
          next_r.dir_neg = 1'b1;
        end
      end
      homing_pkg::PH_LEAVE:
      begin
        if (!final_hit)
        begin
          next_r.edge_pos = actual_position;
          next_r.dir_neg = !r.dir_neg;
          next_r.phase = homing_pkg::PH_REENTER;
        end
      end
      homing_pkg::PH_REENTER:
      begin
        if (final_hit)
        begin
          // Current position re-expressed against the new zero
          next_r.motion.load = 1'b1;
          next_r.motion.load_value = actual_position - mid_pos;
          if (two_switch)
          begin
            next_r.distance = span[homing_pkg::POS_W-1] ?
              -span : span;
          end
          next_r.busy = 1'b0;
          next_r.phase = homing_pkg::PH_IDLE;
        end
      end
      default:
      begin
        next_r.busy = 1'b0;
        next_r.phase = homing_pkg::PH_IDLE;
      end
    endcase

    // Stop overrides every phase and leaves results untouched
    if (cmd_stop)
    begin
      next_r.phase = homing_pkg::PH_IDLE;
      next_r.busy = 1'b0;
      next_r.motion.load = 1'b0;
      next_r.motion.load_value = r.motion.load_value;
      next_r.distance = r.distance;
    end

    // Velocity follows the next phase so it leaves from a flop
    unique case (next_r.phase)
      homing_pkg::PH_FIRST, homing_pkg::PH_SEEK:
      begin
        next_r.motion.velocity = next_r.dir_neg ?
          -$signed(r.search_speed) : $signed(r.search_speed);
      end
      homing_pkg::PH_LEAVE, homing_pkg::PH_REENTER:
      begin
        next_r.motion.velocity = next_r.dir_neg ?
          -$signed(r.cal_speed) : $signed(r.cal_speed);
      end
      default:
      begin
        next_r.motion.velocity = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r.phase <= homing_pkg::PH_IDLE;
      r.mode <= homing_pkg::RST_MODE;
      r.search_speed <= homing_pkg::RST_SEARCH_SPEED;
      r.cal_speed <= homing_pkg::RST_CAL_SPEED;
      r.dir_neg <= 1'b0;
      r.first_pos <= '0;
      r.edge_pos <= '0;
      r.distance <= '0;
      r.busy <= 1'b0;
      r.motion <= '0;
      r.ack <= 1'b0;
      r.rdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign motion = r.motion;
  assign busy = r.busy;

endmodule : reference_search

// file: hdl/homing_pkg.sv
// Purpose: shared constants and types for the reference search sequencer
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes: speeds are unsigned magnitudes, velocity out is signed
package homing_pkg;

  localparam int POS_W = 32;
  localparam int VEL_W = 24;
  localparam int ADR_W = 5;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_COMMAND = 5'h00;
  localparam logic [ADR_W-1:0] OFS_MODE = 5'h04;
  localparam logic [ADR_W-1:0] OFS_SEARCH_SPEED = 5'h08;
  localparam logic [ADR_W-1:0] OFS_CAL_SPEED = 5'h0c;
  localparam logic [ADR_W-1:0] OFS_STATUS = 5'h10;
  localparam logic [ADR_W-1:0] OFS_DISTANCE = 5'h14;

  // Command word layout
  localparam logic [7:0] OPCODE_REF_SEARCH = 8'h0d;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_TYPE_LSB = 8;
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_STATUS = 2'h2;

  // Mode value layout
  localparam int MODE_SWAP_BIT = 6;
  localparam int MODE_INVERT_BIT = 7;
  localparam logic [5:0] MODE_LEFT_ONLY = 6'h01;
  localparam logic [5:0] MODE_RIGHT_LEFT = 6'h02;
  localparam logic [5:0] MODE_RIGHT_LEFT_MID = 6'h03;
  localparam logic [5:0] MODE_LEFT_MID = 6'h04;
  localparam logic [5:0] MODE_HOME_NEG_REV = 6'h05;
  localparam logic [5:0] MODE_HOME_POS_REV = 6'h06;
  localparam logic [5:0] MODE_HOME_POS = 6'h07;
  localparam logic [5:0] MODE_HOME_NEG = 6'h08;

  // Reset values
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [VEL_W-1:0] RST_SEARCH_SPEED = 24'h000400;
  localparam logic [VEL_W-1:0] RST_CAL_SPEED = 24'h000040;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_FIRST,
    PH_SEEK,
    PH_LEAVE,
    PH_REENTER
  } phase_type;

  typedef struct packed {
    logic left;
    logic right;
    logic home;
  } switch_type;

  typedef struct packed {
    logic signed [VEL_W-1:0] velocity;
    logic load;
    logic signed [POS_W-1:0] load_value;
  } motion_type;

  typedef struct packed {
    phase_type phase;
    logic [7:0] mode;
    logic [VEL_W-1:0] search_speed;
    logic [VEL_W-1:0] cal_speed;
    logic dir_neg;
    logic signed [POS_W-1:0] first_pos;
    logic signed [POS_W-1:0] edge_pos;
    logic [POS_W-1:0] distance;
    logic busy;
    motion_type motion;
    logic ack;
    logic [31:0] rdata;
  } state_type;

endpackage : homing_pkg

// file: dv/homing_props.sv
// Purpose: port checker for the reference search sequencer
// Assumes: one clock domain, clk_en high in the bench
// Notes: bound to every reference_search instance
`timescale 1ns/1ps
module homing_props
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [homing_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Motion
  input homing_pkg::motion_type motion,
  input wire logic busy
);
  logic cmd_wr;
  assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && clk_en &&
    wb_adr_i == homing_pkg::OFS_COMMAND && wb_sel_i[1:0] == 2'h3 &&
    wb_dat_i[7:0] == homing_pkg::OPCODE_REF_SEARCH;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_ack_single: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack held past one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_rdata_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_start_busy: assert property (cmd_wr && !busy && wb_dat_i[9:8] == 2'h0 |=> busy)
    else $error("start did not raise busy");
  chk_stop_halt: assert property (cmd_wr && wb_dat_i[9:8] == 2'h1 |=>
    !busy && motion.velocity == 24'h0 && !motion.load)
    else $error("stop did not halt");
  chk_load_done: assert property (motion.load |-> !busy && motion.velocity == 24'h0)
    else $error("load while moving");
  chk_idle_still: assert property (!busy |-> motion.velocity == 24'h0)
    else $error("motion while idle");
  chk_zero_hold: assert property (!motion.load |-> $stable(motion.load_value))
    else $error("zero changed without load");
endmodule : homing_props
////////////////////////////////////////////////////////////////////////////////
bind reference_search homing_props i_homing_props (.clk_sys(clk_sys), .arst_n(arst_n),
  .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .motion(motion), .busy(busy));

// file: dv/axis_model.sv
// Purpose: stage model with two end switches and a home switch
// Assumes: one velocity unit moves one microstep per cycle
// Notes: park lets the bench place the slider between runs
`timescale 1ns/1ps
module axis_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Bench control
  input wire logic park,
  input wire logic signed [homing_pkg::POS_W-1:0] park_pos,
  input wire logic home_inv,
  // Motor and switches
  input homing_pkg::motion_type motion,
  output homing_pkg::switch_type switches,
  output logic signed [homing_pkg::POS_W-1:0] actual_position
);
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      actual_position <= '0;
    else if (park)
      actual_position <= park_pos;
    else
      actual_position <= actual_position + motion.velocity;
  end
  // Switch zones overlap nothing unless home_inv is set, so each edge is unambiguous
  assign switches.left = actual_position <= -100;
  assign switches.right = actual_position >= 100;
  assign switches.home = (actual_position >= 40 && actual_position <= 60) ^ home_inv;
endmodule : axis_model

// file: dv/reference_search_test.sv
// Purpose: self-checking bench for the reference search sequencer
// Assumes: search speed 4, calibration speed 1 after setup
// Notes: midpoints checked within three microsteps of the switch edge
`timescale 1ns/1ps
module reference_search_test;
  logic clk_sys = 0, arst_n = 0, cyc = 0, we = 0, park = 0, inv = 0, load_seen = 0;
  logic cal_seen = 0, busy, ack;
  logic [3:0] sel = 4'hf;
  logic [homing_pkg::ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0, rdat, rd, d0;
  logic signed [31:0] ppos = '0, pos;
  homing_pkg::switch_type sw;
  homing_pkg::motion_type motion;
  int error_cnt = 0, samples_checked = 0, cycles = 0, mid = 0;
  logic [7:0] modes [13] = '{8'h01, 8'h41, 8'h02, 8'h42, 8'h03, 8'h43, 8'h04, 8'h44,
    8'h05, 8'h06, 8'h07, 8'h08, 8'h87};
  int froms [13] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 80, -150, 100, -150};
  int mids [13] = '{-100, 100, -100, 100, -100, 100, -100, 100, 40, 60, 40, 60, 40};
  reference_search i_reference_search (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .switches(sw),
    .actual_position(pos), .motion(motion), .busy(busy));
  axis_model i_axis_model (.clk_sys(clk_sys), .arst_n(arst_n), .park(park),
    .park_pos(ppos), .home_inv(inv), .motion(motion), .switches(sw),
    .actual_position(pos));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (motion.load === 1'b1)
    begin
      load_seen <= 1;
      mid <= int'(pos - motion.load_value);
    end
    if (busy === 1'b1 && motion.velocity === 24'h000001)
      cal_seen <= 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0;
    @(posedge clk_sys);
  endtask : wb
  task automatic home(input int i);
    int n;
    n = 0;
    park <= 1;
    ppos <= froms[i];
    inv <= (i == 12);
    load_seen <= 0;
    @(posedge clk_sys);
    park <= 0;
    wb(1, homing_pkg::OFS_MODE, {24'h0, modes[i]});
    wb(1, homing_pkg::OFS_COMMAND, 32'h0000000d);
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    check("load", {31'h0, load_seen}, 32'h1);
    check("midpoint", {31'h0, mid - mids[i] <= 3 && mids[i] - mid <= 3}, 32'h1);
  endtask : home
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1;
    @(posedge clk_sys);
    wb(0, homing_pkg::OFS_MODE, 0);
    check("mode", rd, 32'h00000001);
    wb(0, homing_pkg::OFS_SEARCH_SPEED, 0);
    check("search", rd, 32'h00000400);
    wb(0, homing_pkg::OFS_CAL_SPEED, 0);
    check("cal", rd, 32'h00000040);
    wb(0, 5'h18, 0);
    check("unmapped", rd, 32'h0);
    wb(1, homing_pkg::OFS_SEARCH_SPEED, 32'h4);
    wb(1, homing_pkg::OFS_CAL_SPEED, 32'h1);
    wb(1, homing_pkg::OFS_COMMAND, 32'h0000000c);
    wb(0, homing_pkg::OFS_STATUS, 0);
    check("bad opcode", rd, 32'h0);
    // Start with the opcode lane selected but not the type lane must be ignored
    sel <= 4'h1;
    wb(1, homing_pkg::OFS_COMMAND, 32'h0000000d);
    sel <= 4'hf;
    wb(0, homing_pkg::OFS_STATUS, 0);
    check("partial sel", rd, 32'h0);
    for (int i = 0; i < 13; i++)
    begin
      home(i);
      wb(0, homing_pkg::OFS_DISTANCE, 0);
      if (i >= 2 && i <= 5)
        check("distance", {31'h0, rd >= 198 && rd <= 210}, 32'h1);
    end
    check("cal speed", {31'h0, cal_seen}, 32'h1);
    d0 = rd;
    home(0);
    park <= 1;
    ppos <= '0;
    load_seen <= 0;
    @(posedge clk_sys);
    park <= 0;
    wb(1, homing_pkg::OFS_COMMAND, 32'h0000000d);
    check("velocity", {8'h0, motion.velocity}, 32'h00fffffc);
    wb(0, homing_pkg::OFS_STATUS, 0);
    check("busy", rd & 32'h1, 32'h1);
    wb(1, homing_pkg::OFS_COMMAND, 32'h0000010d);
    wb(0, homing_pkg::OFS_STATUS, 0);
    check("stopped", rd, 32'h0);
    check("halt", {8'h0, motion.velocity}, 32'h0);
    check("no load", {31'h0, load_seen}, 32'h0);
    wb(0, homing_pkg::OFS_DISTANCE, 0);
    check("distance kept", rd, d0);
    print_verdict();
  end
endmodule : reference_search_test
